// ===== rtl/oare_pkg.sv
package oare_pkg;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int ADDR_W = 8;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [12:0] ISR_VEC = 13'h0004;
  localparam logic MIE_RST = 1'b0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ****************************************************************
  // Operations handled here
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NONE,
    OP_OR_IMM,
    OP_OR_MEM,
    OP_RET,
    OP_RET_LIT,
    OP_RETURN_FROM_INTERRUPT
  } oare_op_t;

  typedef struct packed {
    oare_op_t op;
    logic [7:0] literal;
    logic [7:0] mem_addr;
  } oare_instr_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } oare_mem_wr_t;

endpackage : oare_pkg

// ===== rtl/oare_or_unit.sv
`timescale 1ns/100ps
module oare_or_unit (
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  output logic [7:0] result_out,
  output logic zero_out
);

  assign result_out = a_in | b_in;
  assign zero_out = (result_out == oare_pkg::ZERO_BYTE);

endmodule : oare_or_unit

// ===== rtl/oare_exec.sv
`timescale 1ns/100ps
module oare_exec (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic instr_valid_in,
  input wire oare_pkg::oare_instr_t instr_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [12:0] stack_top_in,
  input wire logic irq_pending_in,
  input wire logic mie_clear_in,
  input wire logic [3:0] other_flags_in,
  output logic [7:0] working_register_out,
  output logic zero_flag_out,
  output logic [3:0] other_flags_out,
  output logic master_interrupt_enable_out,
  output logic [12:0] pc_out,
  output logic pc_load_out,
  output logic stack_pop_out,
  output logic stack_push_out,
  output logic [12:0] push_data_out,
  output logic irq_entry_out,
  output oare_pkg::oare_mem_wr_t mem_wr_out
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic is_return(input oare_pkg::oare_op_t op);
    is_return = (op == oare_pkg::OP_RET) || (op == oare_pkg::OP_RET_LIT)
             || (op == oare_pkg::OP_RETURN_FROM_INTERRUPT);
  endfunction : is_return

  function automatic logic is_or(input oare_pkg::oare_op_t op);
    is_or = (op == oare_pkg::OP_OR_IMM) || (op == oare_pkg::OP_OR_MEM);
  endfunction : is_or

  oare_pkg::oare_op_t op;
  logic [7:0] or_b;
  logic [7:0] or_res;
  logic or_zero;
  logic do_or;
  logic do_ret;
  logic take_irq;

  assign op = instr_valid_in ? instr_in.op : oare_pkg::OP_NONE;
  assign do_or = is_or(op);
  assign do_ret = is_return(op);
  assign or_b = (op == oare_pkg::OP_OR_MEM) ? mem_rdata_in
                                            : instr_in.literal;

  oare_or_unit u_or (
    .a_in(working_register_out),
    .b_in(or_b),
    .result_out(or_res),
    .zero_out(or_zero)
  );

  // ****************************************************************
  // Interrupt entry
  // ****************************************************************
  // Entry only while enabled; after interrupt return the enable is
  // already set next cycle, so a pending request enters before the
  // restored address executes.
  assign take_irq = master_interrupt_enable_out && irq_pending_in
                 && !instr_valid_in;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      master_interrupt_enable_out <= oare_pkg::MIE_RST;
    end else if (op == oare_pkg::OP_RETURN_FROM_INTERRUPT) begin
      master_interrupt_enable_out <= 1'b1;
    end else if (take_irq || mie_clear_in) begin
      master_interrupt_enable_out <= 1'b0;
    end
  end

  // ****************************************************************
  // Working register
  // ****************************************************************
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      working_register_out <= oare_pkg::WREG_RST;
    end else if (op == oare_pkg::OP_OR_IMM) begin
      working_register_out <= or_res;
    end else if (op == oare_pkg::OP_RET_LIT) begin
      working_register_out <= instr_in.literal;
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      zero_flag_out <= 1'b0;
      other_flags_out <= 4'h0;
    end else begin
      other_flags_out <= other_flags_in;
      if (do_or) begin
        zero_flag_out <= or_zero;
      end
    end
  end

  // ****************************************************************
  // Data memory write
  // ****************************************************************
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_wr_out <= '0;
    end else begin
      mem_wr_out.we <= (op == oare_pkg::OP_OR_MEM);
      mem_wr_out.addr <= instr_in.mem_addr;
      mem_wr_out.data <= or_res;
    end
  end

  // ****************************************************************
  // Program counter and stack
  // ****************************************************************
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_out <= oare_pkg::PC_RST;
      pc_load_out <= 1'b0;
      stack_pop_out <= 1'b0;
      stack_push_out <= 1'b0;
      push_data_out <= oare_pkg::PC_RST;
      irq_entry_out <= 1'b0;
    end else begin
      pc_load_out <= do_ret || take_irq;
      stack_pop_out <= do_ret;
      stack_push_out <= take_irq;
      irq_entry_out <= take_irq;
      if (do_ret) begin
        pc_out <= stack_top_in;
      end else if (take_irq) begin
        push_data_out <= pc_out;
        pc_out <= oare_pkg::ISR_VEC;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_or_imm_wreg: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) (op == oare_pkg::OP_OR_IMM) |=>
    working_register_out == ($past(working_register_out)
      | $past(instr_in.literal)))
    else $error("immediate OR result wrong");

  a_or_mem_keep: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) (op == oare_pkg::OP_OR_MEM) |=>
    $stable(working_register_out) && mem_wr_out.we
    && mem_wr_out.addr == $past(instr_in.mem_addr)
    && mem_wr_out.data == ($past(working_register_out)
      | $past(mem_rdata_in)))
    else $error("memory OR wrong");

  a_or_flags: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) do_or |=>
    other_flags_out == $past(other_flags_in))
    else $error("OR touched other flags");

  a_ret_pc: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) do_ret |=>
    pc_out == $past(stack_top_in) && stack_pop_out && pc_load_out)
    else $error("return did not restore pc");

  a_ret_lit_wreg: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) (op == oare_pkg::OP_RET_LIT) |=>
    working_register_out == $past(instr_in.literal))
    else $error("literal return load wrong");

  a_ret_zero_kept: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) do_ret |=> $stable(zero_flag_out))
    else $error("return changed zero flag");

  a_return_from_interrupt_enable: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) (op == oare_pkg::OP_RETURN_FROM_INTERRUPT) |=>
    master_interrupt_enable_out)
    else $error("interrupt return left enable clear");

  a_irq_gated: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) irq_entry_out |->
    $past(master_interrupt_enable_out))
    else $error("interrupt entered while disabled");

  a_return_from_interrupt_pending: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    (op == oare_pkg::OP_RETURN_FROM_INTERRUPT) && irq_pending_in ##1
    (irq_pending_in && !instr_valid_in && !mie_clear_in) |=>
    irq_entry_out && push_data_out == $past(stack_top_in, 2))
    else $error("pending interrupt not serviced first");

  a_zero_flag: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) do_or |=>
    zero_flag_out == ((($past(op) == oare_pkg::OP_OR_IMM)
      ? working_register_out : mem_wr_out.data) == oare_pkg::ZERO_BYTE))
    else $error("zero flag wrong");

  a_irq_refused: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) instr_valid_in |=> !irq_entry_out)
    else $error("interrupt entered during instruction");

  a_irq_vector: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    master_interrupt_enable_out && irq_pending_in && !instr_valid_in |=>
    irq_entry_out && stack_push_out && pc_load_out
    && pc_out == oare_pkg::ISR_VEC && push_data_out == $past(pc_out)
    && !master_interrupt_enable_out)
    else $error("interrupt entry wrong");

  a_mie_rise: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) $rose(master_interrupt_enable_out) |->
    $past(op) == oare_pkg::OP_RETURN_FROM_INTERRUPT)
    else $error("enable set without interrupt return");

endmodule : oare_exec

// ===== tb/oare_exec_test.sv
`timescale 1ns/100ps
module oare_exec_test;
  // ****************************************************************
  // Expected results, one per clock
  // ****************************************************************
  typedef struct packed {
    logic [7:0] wreg;
    logic zero;
    logic mie;
    logic [12:0] pc;
    logic [4:0] pulses;
    logic [12:0] pdata;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [3:0] flags;
  } oare_note_t;

  `define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin \
    n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic instr_valid_in = 1'b0;
  oare_pkg::oare_instr_t instr_in = '0;
  logic [7:0] mem_rdata_in = 8'h00;
  logic [12:0] stack_top_in = 13'h0000;
  logic irq_pending_in = 1'b0;
  logic mie_clear_in = 1'b0;
  logic [3:0] other_flags_in = 4'h0;
  logic [7:0] working_register_out;
  logic zero_flag_out, master_interrupt_enable_out, pc_load_out;
  logic stack_pop_out, stack_push_out, irq_entry_out;
  logic [3:0] other_flags_out;
  logic [12:0] pc_out, push_data_out;
  oare_pkg::oare_mem_wr_t mem_wr_out;
  oare_note_t notes[$];
  oare_note_t pend, n, g;
  logic has_pend = 1'b0;
  int n_fail = 0;
  int num_checks = 0;

  oare_exec dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .mem_rdata_in(mem_rdata_in), .stack_top_in(stack_top_in),
    .irq_pending_in(irq_pending_in), .mie_clear_in(mie_clear_in),
    .other_flags_in(other_flags_in),
    .working_register_out(working_register_out),
    .zero_flag_out(zero_flag_out), .other_flags_out(other_flags_out),
    .master_interrupt_enable_out(master_interrupt_enable_out),
    .pc_out(pc_out), .pc_load_out(pc_load_out),
    .stack_pop_out(stack_pop_out), .stack_push_out(stack_push_out),
    .push_data_out(push_data_out), .irq_entry_out(irq_entry_out),
    .mem_wr_out(mem_wr_out));

  initial begin
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // ****************************************************************
  // Driver with reference model; pulses are {load,pop,push,entry,we}
  // ****************************************************************
  task automatic step(input logic v, input oare_pkg::oare_op_t op,
      input logic [7:0] lit, input logic [7:0] rd,
      input logic [12:0] top, input logic irq, input logic clr);
    logic [7:0] ad;
    logic [3:0] of;
    logic [7:0] r;
    ad = 8'($urandom);
    of = 4'($urandom);
    @(posedge sys_clk_in);
    if (has_pend) notes.push_back(pend);
    instr_valid_in <= v;
    instr_in <= '{op: op, literal: lit, mem_addr: ad};
    mem_rdata_in <= rd;
    stack_top_in <= top;
    irq_pending_in <= irq;
    mie_clear_in <= clr;
    other_flags_in <= of;
    n = pend;
    n.pulses = 5'h00;
    n.flags = of;
    n.waddr = ad;
    if (v) begin
      case (op)
        oare_pkg::OP_OR_IMM: begin
          r = pend.wreg | lit;
          n.wreg = r;
          n.zero = (r == 8'h00);
        end
        oare_pkg::OP_OR_MEM: begin
          r = pend.wreg | rd;
          n.wdata = r;
          n.zero = (r == 8'h00);
          n.pulses = 5'h01;
        end
        oare_pkg::OP_RET: begin
          n.pc = top;
          n.pulses = 5'h18;
        end
        oare_pkg::OP_RET_LIT: begin
          n.pc = top;
          n.wreg = lit;
          n.pulses = 5'h18;
        end
        oare_pkg::OP_RETURN_FROM_INTERRUPT: begin
          n.pc = top;
          n.mie = 1'b1;
          n.pulses = 5'h18;
        end
        default: n.pulses = 5'h00;
      endcase
    end else if (pend.mie && irq) begin
      n.pdata = pend.pc;
      n.pc = oare_pkg::ISR_VEC;
      n.mie = 1'b0;
      n.pulses = 5'h16;
    end
    if (clr && !(v && op == oare_pkg::OP_RETURN_FROM_INTERRUPT)) begin
      n.mie = 1'b0;
    end
    pend = n;
    has_pend = 1'b1;
  endtask : step

  // ****************************************************************
  // Watcher
  // ****************************************************************
  always @(negedge sys_clk_in) begin
    while (notes.size() > 0) begin
      g = notes.pop_front();
      `CHK("wreg", g.wreg, working_register_out)
      `CHK("zero", g.zero, zero_flag_out)
      `CHK("flags", g.flags, other_flags_out)
      `CHK("mie", g.mie, master_interrupt_enable_out)
      `CHK("pc", g.pc, pc_out)
      `CHK("pulses", g.pulses, {pc_load_out, stack_pop_out,
        stack_push_out, irq_entry_out, mem_wr_out.we})
      if (g.pulses[2]) `CHK("pdata", g.pdata, push_data_out)
      if (g.pulses[0]) `CHK("wr", {g.waddr, g.wdata},
        {mem_wr_out.addr, mem_wr_out.data})
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #(3000 * 100);
    n_fail++;
    tally_and_finish();
  end

  // ****************************************************************
  // Directed then random sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h6d73));
    pend = '0;
    repeat (6) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    step(1, oare_pkg::OP_OR_IMM, 8'h00, 8'h00, 13'h0, 1, 0);
    step(0, oare_pkg::OP_NONE, 8'h00, 8'h00, 13'h0, 1, 0);
    step(1, oare_pkg::OP_OR_MEM, 8'h00, 8'h00, 13'h0, 0, 0);
    step(1, oare_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h5a, 13'h1abc, 1, 0);
    step(1, oare_pkg::OP_OR_IMM, 8'h81, 8'h00, 13'h0, 1, 0);
    step(0, oare_pkg::OP_NONE, 8'h00, 8'h00, 13'h0, 1, 0);
    step(1, oare_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00, 13'h0123, 0, 0);
    step(0, oare_pkg::OP_NONE, 8'h00, 8'h00, 13'h0, 0, 1);
    step(1, oare_pkg::OP_RET_LIT, 8'h00, 8'h00, 13'h1fff, 0, 0);
    step(1, oare_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00, 13'h0abc, 1, 0);
    step(0, oare_pkg::OP_NONE, 8'h00, 8'h00, 13'h0, 1, 0);
    repeat (300) begin
      step(1'($urandom_range(0, 3) != 0),
        oare_pkg::oare_op_t'($urandom_range(1, 5)), 8'($urandom),
        8'($urandom), 13'($urandom), 1'($urandom),
        1'($urandom_range(0, 7) == 0));
    end
    step(0, oare_pkg::OP_NONE, 8'h00, 8'h00, 13'h0, 0, 0);
    @(posedge sys_clk_in);
    notes.push_back(pend);
    @(negedge sys_clk_in);
    #1;
    tally_and_finish();
  end
endmodule : oare_exec_test
